// ===== src/ieu_pkg.sv
// Package for the interrupt expansion unit: sizes, timing counts, types.
// Assumes a single CPU clock domain with a synchronous active-high reset.
package ieu_pkg;
   // Expander geometry
   localparam int NUM_REQ      = 96;   // Request inputs
   localparam int GROUP_SIZE   = 8;    // Requests per group
   localparam int NUM_GROUPS   = 12;   // CPU lines fed by the expander
   localparam int NUM_USED     = 45;   // Requests wired to peripherals
   localparam int VEC_W        = 22;   // Vector entry width
   localparam int IDX_W        = 7;    // Request index width
   localparam int SUB_W        = 3;    // Index within a group
   // Timer routing: timer zero enters at this request index
   localparam logic [IDX_W-1:0] TIMER0_REQ_IDX = 7'h06;
   // Service sequence length
   localparam int FETCH_CYCLES = 8;
   localparam logic [3:0] FETCH_LAST = 4'h7;
   // Time-stamp counter width
   localparam int STAMP_W      = 16;
   localparam logic [STAMP_W-1:0] STAMP_RESET = 16'h0000;
   // Number of external inputs (a, b, combined c/nmi)
   localparam int NUM_EXT      = 3;
   localparam int EXT_C        = 2;

   // Low-power modes
   typedef enum logic [1:0] {LPM_RUN, LPM_IDLE, LPM_STANDBY, LPM_HALT}
      ieu_lpm_t;

   // Answer to the CPU vector fetch
   typedef struct packed {
      logic             valid;  // Vector ready for the CPU
      logic [3:0]       line;   // CPU line being serviced, 1 to 12
      logic [VEC_W-1:0] vector; // Fetched vector
   } ieu_vec_rsp_t;

   // External pin configuration for one input
   typedef struct packed {
      logic enable;   // Input enabled
      logic rising;   // 1 rising edge, 0 falling edge
   } ieu_ext_cfg_t;
endpackage

// ===== src/ieu_ext_edge.sv
// One external interrupt input: synchroniser, edge detect, time stamp.
// Assumes the pin is sampled on ref_clk; configuration is static-ish.
`timescale 1ns/1ps
module ieu_ext_edge
#(
   parameter int STAMP_W = ieu_pkg::STAMP_W
)
(
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 srst,
   // Pin and configuration
   input  wire logic                 pinIn,
   input  wire ieu_pkg::ieu_ext_cfg_t cfg,
   // Results
   output logic                      edgeSeen,
   output logic [STAMP_W-1:0]        stamp
);
   logic syncA;       // First stage, read only by syncB
   logic syncB;       // Second stage
   logic syncPrev;    // Previous synchronised level
   logic risingEdge;  // Synchronised rising transition
   logic fallingEdge; // Synchronised falling transition
   logic validEdge;   // Edge of the selected polarity

   assign risingEdge  = syncB & ~syncPrev;
   assign fallingEdge = ~syncB & syncPrev;
   assign validEdge   = cfg.enable &
                        (cfg.rising ? risingEdge : fallingEdge);

   // Two-stage synchroniser and history
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         syncA    <= 1'b0;
         syncB    <= 1'b0;
         syncPrev <= 1'b0;
      end
      else
      begin
         syncA    <= pinIn;
         syncB    <= syncA;
         syncPrev <= syncB;
      end
   end

   // Free-running stamp, cleared on a valid edge
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         stamp    <= '0;
         edgeSeen <= 1'b0;
      end
      else
      begin
         stamp    <= validEdge ? '0 : stamp + 1'b1;
         edgeSeen <= validEdge;
      end
   end

   // Stamp clears the cycle after a valid edge
   property p_stamp_clear;
      @(posedge ref_clk) disable iff (srst)
      validEdge |=> (stamp == '0) && edgeSeen;
   endproperty
   a_stamp_clear: assert property (p_stamp_clear)
      else $error("stamp not cleared after edge");

   // An edge needs the synchronised level at the selected polarity
   property p_edge_polarity;
      @(posedge ref_clk) disable iff (srst)
      edgeSeen |-> ($past(syncB) == $past(cfg.rising)) && $past(cfg.enable);
   endproperty
   a_edge_polarity: assert property (p_edge_polarity)
      else $error("edge flagged at wrong polarity");
endmodule

// ===== src/ieu_top.sv
// Top of the interrupt expansion unit: groups, vectors, external inputs,
// timer routing and wake logic. Assumes the CPU acknowledges one line
// at a time and that all inputs are synchronous to ref_clk.
//
// Overview of operation
// - 96 requests, groups of 8, 12 lines
// - Only 45 requests connected; rest inactive
// - Each request has writable vector entry
// - Vector fetch and save take 8 cycles
// - Per-request enable gates group line
// - Priority from fixed order plus enables
// - Three external inputs; third shares nonmaskable pin
// - Each external input: polarity and enable
// - 16-bit stamp counter cleared on edge
// - Timer zero enters as expander request
// - Timer one may drive line 13
// - Timer two drives line 14 directly
// - Idle: enabled peripheral interrupt wakes CPU
// - Standby: external event wakes all
// - Halt: only nonmaskable input wakes
`timescale 1ns/1ps
module ieu_top
#(
   parameter int NUM_REQ  = ieu_pkg::NUM_REQ,
   parameter int NUM_USED = ieu_pkg::NUM_USED,
   parameter int VEC_W    = ieu_pkg::VEC_W
)
(
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        srst,
   // Peripheral requests, index 0 upward
   input  wire logic [NUM_USED-1:0]         periphReq,
   input  wire logic [NUM_REQ-1:0]          reqEnable,
   // Timer interrupts
   input  wire logic                        timer0Irq,
   input  wire logic                        timer1Irq,
   input  wire logic                        timer1Route,
   input  wire logic                        timer2Irq,
   // Vector table write port
   input  wire logic                        vecWrEn,
   input  wire logic [ieu_pkg::IDX_W-1:0]   vecWrIdx,
   input  wire logic [VEC_W-1:0]            vecWrData,
   // CPU acknowledge of a line, 1 to 12
   input  wire logic                        cpuAck,
   input  wire logic [3:0]                  cpuAckLine,
   // External pins and their configuration
   input  wire logic                        extIrqAPin,
   input  wire logic                        extIrqBPin,
   input  wire logic                        extCombinedIrqPin,
   input  wire ieu_pkg::ieu_ext_cfg_t       extIrqACfg,
   input  wire ieu_pkg::ieu_ext_cfg_t       extIrqBCfg,
   input  wire ieu_pkg::ieu_ext_cfg_t       extIrqCCfg,
   input  wire ieu_pkg::ieu_ext_cfg_t       extNmiCfg,
   // Low-power mode of the device
   input  wire ieu_pkg::ieu_lpm_t           lpMode,
   // CPU interrupt lines
   output logic [ieu_pkg::NUM_GROUPS-1:0]   cpuIntLines,
   output logic                             cpuIntLineThirteen,
   output logic                             cpuIntLineFourteen,
   output logic                             extIrqA,
   output logic                             extIrqB,
   output logic                             extIrqC,
   output logic                             extNonmaskableIrq,
   // Time stamps
   output logic [ieu_pkg::STAMP_W-1:0]      stampA,
   output logic [ieu_pkg::STAMP_W-1:0]      stampB,
   output logic [ieu_pkg::STAMP_W-1:0]      stampC,
   // Vector answer
   output ieu_pkg::ieu_vec_rsp_t            vecRsp,
   // Wake requests
   output logic                             wakeCpu,
   output logic                             wakePeriph
);
   localparam int G  = ieu_pkg::GROUP_SIZE;
   localparam int NG = ieu_pkg::NUM_GROUPS;

   typedef enum {FS_IDLE, FS_FETCH} ieu_fetch_t;

   logic [NUM_REQ-1:0]     allReq;       // Full request vector
   logic [NUM_REQ-1:0]     activeReq;    // Requests after enables
   logic [NG-1:0]          groupReq;     // Combined group requests
   logic [VEC_W-1:0]       vecRam [NUM_REQ]; // Vector table
   ieu_fetch_t             fetchState;   // Service sequencer
   logic [3:0]             fetchCnt;     // Cycles into the fetch
   logic [3:0]             fetchLine;    // Line being serviced
   logic [ieu_pkg::IDX_W-1:0] fetchIdx;  // Captured winning index
   logic [ieu_pkg::IDX_W-1:0] winIdx;    // Winner of acked group
   logic                   winValid;     // Acked group has a winner
   logic [3:0]             ackGroup;     // Zero-based acked group
   logic                   edgeA;        // Valid edge, input a
   logic                   edgeB;        // Valid edge, input b
   logic                   edgeC;        // Valid edge, maskable c
   logic                   edgeNmi;      // Valid edge, nonmaskable
   logic                   anyExtEdge;   // Any external event
   logic                   next_wakeCpu; // Wake decision
   logic                   next_wakePer; // Peripheral wake decision

   // First set request in a group of eight, lowest index wins
   function automatic logic [ieu_pkg::SUB_W:0] first_set
      (input logic [G-1:0] bits);
      logic [ieu_pkg::SUB_W:0] res;
      res = '0;
      for (int i = G - 1; i >= 0; i--)
         if (bits[i])
            res = {1'b1, ieu_pkg::SUB_W'(i)};
      return res;
   endfunction

   // Timer zero at its slot, used peripherals elsewhere, rest tied low
   always_comb
   begin
      allReq = '0;
      allReq[NUM_USED-1:0] = periphReq;
      allReq[ieu_pkg::TIMER0_REQ_IDX] = timer0Irq;
   end

   assign activeReq = allReq & reqEnable;

   // One OR per group of eight
   genvar g;
   generate
      for (g = 0; g < NG; g++)
      begin : gGroup
         assign groupReq[g] = |activeReq[g*G +: G];
      end
   endgenerate

   assign ackGroup = cpuAckLine - 4'h1;
   // Fixed order combined with software enables decides the winner
   wire [ieu_pkg::SUB_W:0] winSel =
      first_set(activeReq[ackGroup*G +: G]);
   assign winValid = winSel[ieu_pkg::SUB_W];
   assign winIdx   = ieu_pkg::IDX_W'({ackGroup, winSel[ieu_pkg::SUB_W-1:0]});

   // External edge detectors; c and nmi share the combined pin
   ieu_ext_edge u_extA (.ref_clk(ref_clk), .srst(srst), .pinIn(extIrqAPin),
      .cfg(extIrqACfg), .edgeSeen(edgeA), .stamp(stampA));
   ieu_ext_edge u_extB (.ref_clk(ref_clk), .srst(srst), .pinIn(extIrqBPin),
      .cfg(extIrqBCfg), .edgeSeen(edgeB), .stamp(stampB));
   ieu_ext_edge u_extC (.ref_clk(ref_clk), .srst(srst),
      .pinIn(extCombinedIrqPin), .cfg(extIrqCCfg),
      .edgeSeen(edgeC), .stamp(stampC));
   ieu_ext_edge u_extN (.ref_clk(ref_clk), .srst(srst),
      .pinIn(extCombinedIrqPin), .cfg(extNmiCfg),
      .edgeSeen(edgeNmi), .stamp());

   assign anyExtEdge = edgeA | edgeB | edgeC | edgeNmi;

   // Wake decision per low-power mode
   always_comb
   begin
      next_wakeCpu = 1'b0;
      next_wakePer = 1'b0;
      case (lpMode)
         ieu_pkg::LPM_IDLE:
            next_wakeCpu = |groupReq;
         ieu_pkg::LPM_STANDBY:
         begin
            next_wakeCpu = anyExtEdge;
            next_wakePer = anyExtEdge;
         end
         ieu_pkg::LPM_HALT:
         begin
            next_wakeCpu = edgeNmi;
            next_wakePer = edgeNmi;
         end
         default:
            next_wakeCpu = 1'b0;
      endcase
   end

   // Vector table writes, any time
   always_ff @(posedge ref_clk)
   begin
      if (vecWrEn && vecWrIdx < ieu_pkg::IDX_W'(NUM_REQ))
         vecRam[vecWrIdx] <= vecWrData;
   end

   // Interrupt lines and wake outputs
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cpuIntLines        <= '0;
         cpuIntLineThirteen <= 1'b0;
         cpuIntLineFourteen <= 1'b0;
         extIrqA            <= 1'b0;
         extIrqB            <= 1'b0;
         extIrqC            <= 1'b0;
         extNonmaskableIrq  <= 1'b0;
         wakeCpu            <= 1'b0;
         wakePeriph         <= 1'b0;
      end
      else
      begin
         cpuIntLines        <= groupReq;
         cpuIntLineThirteen <= timer1Route ? timer1Irq : edgeC;
         cpuIntLineFourteen <= timer2Irq;
         extIrqA            <= edgeA;
         extIrqB            <= edgeB;
         extIrqC            <= edgeC;
         extNonmaskableIrq  <= edgeNmi;
         wakeCpu            <= next_wakeCpu;
         wakePeriph         <= next_wakePer;
      end
   end

   // Service sequencer: capture winner, answer after eight cycles
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         fetchState <= FS_IDLE;
         fetchCnt   <= '0;
         fetchLine  <= '0;
         fetchIdx   <= '0;
         vecRsp     <= '0;
      end
      else
      begin
         vecRsp.valid <= 1'b0;
         case (fetchState)
            FS_IDLE:
               // Only a line that has a winner starts a fetch
               if (cpuAck && cpuAckLine != 4'h0 &&
                   cpuAckLine <= 4'(NG) && winValid)
               begin
                  fetchState <= FS_FETCH;
                  fetchCnt   <= '0;
                  fetchLine  <= cpuAckLine;
                  fetchIdx   <= winIdx;
               end
            FS_FETCH:
               if (fetchCnt == ieu_pkg::FETCH_LAST - 4'h1)
               begin
                  fetchState    <= FS_IDLE;
                  vecRsp.valid  <= 1'b1;
                  vecRsp.line   <= fetchLine;
                  vecRsp.vector <= vecRam[fetchIdx];
               end
               else
                  fetchCnt <= fetchCnt + 4'h1;
            default:
               fetchState <= FS_IDLE;
         endcase
      end
   end

   // Fetch answer comes eight cycles after the acknowledge
   property p_fetch_len;
      @(posedge ref_clk) disable iff (srst)
      (fetchState == FS_IDLE && cpuAck && cpuAckLine != 4'h0 &&
       cpuAckLine <= 4'(NG) && winValid)
      |=> !vecRsp.valid [*7] ##1 vecRsp.valid;
   endproperty
   a_fetch_len: assert property (p_fetch_len)
      else $error("vector answer not at cycle eight");

   // A group line follows its enabled requests
   property p_group_line;
      @(posedge ref_clk) disable iff (srst)
      ##1 cpuIntLines == $past(groupReq);
   endproperty
   a_group_line: assert property (p_group_line)
      else $error("group line mismatch");

   // A fully disabled group zero never raises its line
   property p_enable_gate;
      @(posedge ref_clk) disable iff (srst)
      (reqEnable[G-1:0] == '0) |=> !cpuIntLines[0];
   endproperty
   a_enable_gate: assert property (p_enable_gate)
      else $error("disabled group raised its line");

   // Timer two mirrors onto line fourteen
   property p_timer2;
      @(posedge ref_clk) disable iff (srst)
      timer2Irq |=> cpuIntLineFourteen;
   endproperty
   a_timer2: assert property (p_timer2)
      else $error("line fourteen missed timer two");

   // Timer one routed to line thirteen
   property p_timer1;
      @(posedge ref_clk) disable iff (srst)
      (timer1Route && timer1Irq) |=> cpuIntLineThirteen;
   endproperty
   a_timer1: assert property (p_timer1)
      else $error("line thirteen missed timer one");

   // Halt wake only from the nonmaskable edge
   property p_halt_wake;
      @(posedge ref_clk) disable iff (srst)
      wakeCpu && $past(lpMode) == ieu_pkg::LPM_HALT |-> $past(edgeNmi);
   endproperty
   a_halt_wake: assert property (p_halt_wake)
      else $error("halt woken by other source");

   // Standby wake on external event
   property p_standby_wake;
      @(posedge ref_clk) disable iff (srst)
      (lpMode == ieu_pkg::LPM_STANDBY && anyExtEdge) |=>
         wakeCpu && wakePeriph;
   endproperty
   a_standby_wake: assert property (p_standby_wake)
      else $error("standby not woken by external edge");

   // Idle wake on an enabled request
   property p_idle_wake;
      @(posedge ref_clk) disable iff (srst)
      (lpMode == ieu_pkg::LPM_IDLE && |groupReq) |=> wakeCpu;
   endproperty
   a_idle_wake: assert property (p_idle_wake)
      else $error("idle not woken by enabled request");

   // Groups above the wired requests never raise their line
   property p_tied;
      @(posedge ref_clk) disable iff (srst)
      cpuIntLines[NG-1:(NUM_USED+G-1)/G] == '0;
   endproperty
   a_tied: assert property (p_tied)
      else $error("unconnected request asserted");

   c_fetch: cover property (@(posedge ref_clk) vecRsp.valid);
   c_halt:  cover property (@(posedge ref_clk)
      lpMode == ieu_pkg::LPM_HALT && wakeCpu);
   c_stamp: cover property (@(posedge ref_clk) edgeA ##3 edgeA);
endmodule

// ===== sim/ieu_cpu_model.sv
// CPU core model: acks one expander line and times the vector answer.
// Assumes the bench pulses go for one cycle and holds goLine meanwhile.
`timescale 1ns/1ps
module ieu_cpu_model
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  srst,
   // Command from the bench
   input  wire logic                  go,
   input  wire logic [3:0]            goLine,
   input  wire logic [3:0]            ackDelay,
   // Expander side
   input  wire ieu_pkg::ieu_vec_rsp_t vecRsp,
   output logic                       cpuAck,
   output logic [3:0]                 cpuAckLine,
   // Results
   output logic                       gotVec,
   output logic [ieu_pkg::VEC_W-1:0]  lastVec,
   output logic [3:0]                 lastLine,
   output logic [4:0]                 latency
);
   logic [3:0] waitCnt;   // Cycles left before the ack
   logic       pending;   // Ack scheduled
   logic       busy;      // Waiting for the vector
   logic [4:0] edgeCnt;   // Index of the current edge after the take

   // Ack after a chosen delay, then count edges to the vector
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         {cpuAck, pending, busy, gotVec} <= 4'h0;
         cpuAckLine <= 4'h0;
         waitCnt    <= 4'h0;
         edgeCnt    <= 5'h00;
         latency    <= 5'h00;
      end
      else if (go)
      begin
         pending <= 1'b1;
         gotVec  <= 1'b0;
         waitCnt <= ackDelay;
      end
      else if (cpuAck)
      begin
         // Ack taken at this edge; released line shows inverse value
         cpuAck     <= 1'b0;
         cpuAckLine <= ~cpuAckLine;
         busy       <= 1'b1;
         edgeCnt    <= 5'h01;
      end
      else if (pending && waitCnt == 4'h0)
      begin
         cpuAck     <= 1'b1;
         cpuAckLine <= goLine;
         pending    <= 1'b0;
      end
      else if (pending)
         waitCnt <= waitCnt - 4'h1;
      else if (busy && vecRsp.valid)
      begin
         // Vector fetched automatically after the ack
         busy     <= 1'b0;
         gotVec   <= 1'b1;
         lastVec  <= vecRsp.vector;
         lastLine <= vecRsp.line;
         latency  <= edgeCnt;
      end
      else if (busy)
      begin
         // Give up after a bounded wait
         busy    <= (edgeCnt != 5'h1f);
         edgeCnt <= edgeCnt + 5'h01;
      end
   end
endmodule

// ===== sim/interrupt_expansion_unit_tb_top.sv
// Self-checking bench for the interrupt expansion unit.
// Assumes the CPU model answers on the expander's vector interface.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      samplesChecked++; \
      if ((got) !== (exp)) \
      begin \
         errorCnt++; \
         $display("Error %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module interrupt_expansion_unit_tb_top;
   logic                  ref_clk, srst;      // Clock and reset
   logic [44:0]           periphReq;          // Peripheral requests
   logic [95:0]           reqEnable;          // Request enables
   logic                  timer0Irq, timer1Irq, timer1Route, timer2Irq;
   logic                  vecWrEn;            // Vector write strobe
   logic [6:0]            vecWrIdx;           // Vector write index
   logic [21:0]           vecWrData;          // Vector write data
   logic                  cpuAck;             // Model ack
   logic [3:0]            cpuAckLine;         // Model ack line
   logic [2:0]            pin;                // External pins a, b, c
   ieu_pkg::ieu_ext_cfg_t cfg [4];            // a, b, c, nmi settings
   ieu_pkg::ieu_lpm_t     lpMode;             // Power mode
   logic [11:0]           cpuIntLines;        // Expander lines
   logic                  line13, line14;     // Direct lines
   logic [3:0]            extOut;             // nmi, c, b, a pulses
   logic [15:0]           stampA, stampB, stampC;
   ieu_pkg::ieu_vec_rsp_t vecRsp;             // Vector answer
   logic                  wakeCpu, wakePeriph;
   logic                  go, gotVec;         // Model command, result
   logic [3:0]            goLine, ackDelay, lastLine;
   logic [21:0]           lastVec;            // Fetched vector
   logic [4:0]            latency;            // Ack to vector edges
   logic                  seenCpu, seenPer;   // Wake seen flags
   int                    errorCnt, samplesChecked, cycles;
   wire  [47:0]           stamps = {stampC, stampB, stampA};

   ieu_top dut_u (.ref_clk(ref_clk), .srst(srst), .periphReq(periphReq),
      .reqEnable(reqEnable), .timer0Irq(timer0Irq), .timer1Irq(timer1Irq),
      .timer1Route(timer1Route), .timer2Irq(timer2Irq),
      .vecWrEn(vecWrEn), .vecWrIdx(vecWrIdx), .vecWrData(vecWrData),
      .cpuAck(cpuAck), .cpuAckLine(cpuAckLine), .extIrqAPin(pin[0]),
      .extIrqBPin(pin[1]), .extCombinedIrqPin(pin[2]),
      .extIrqACfg(cfg[0]), .extIrqBCfg(cfg[1]), .extIrqCCfg(cfg[2]),
      .extNmiCfg(cfg[3]), .lpMode(lpMode), .cpuIntLines(cpuIntLines),
      .cpuIntLineThirteen(line13), .cpuIntLineFourteen(line14),
      .extIrqA(extOut[0]), .extIrqB(extOut[1]), .extIrqC(extOut[2]),
      .extNonmaskableIrq(extOut[3]), .stampA(stampA), .stampB(stampB),
      .stampC(stampC), .vecRsp(vecRsp), .wakeCpu(wakeCpu),
      .wakePeriph(wakePeriph));

   ieu_cpu_model cpu_u (.ref_clk(ref_clk), .srst(srst), .go(go),
      .goLine(goLine), .ackDelay(ackDelay), .vecRsp(vecRsp),
      .cpuAck(cpuAck), .cpuAckLine(cpuAckLine), .gotVec(gotVec),
      .lastVec(lastVec), .lastLine(lastLine), .latency(latency));

   // Clock, cycle ceiling and wake monitor
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cycles++;
      if (wakeCpu === 1'b1) seenCpu = 1'b1;
      if (wakePeriph === 1'b1) seenPer = 1'b1;
      if (cycles == 20000)
      begin
         errorCnt++;
         tally_and_finish();
      end
   end

   // Wait n edges, then let them settle
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Write one vector entry
   task automatic vec_wr(input logic [6:0] idx, input logic [21:0] d);
      @(posedge ref_clk);
      vecWrEn   <= 1'b1;
      vecWrIdx  <= idx;
      vecWrData <= d;
      @(posedge ref_clk);
      vecWrEn   <= 1'b0;
   endtask

   // Ask the model to service a line and check the answer
   task automatic fetch(input logic [3:0] ln, input logic [3:0] dly,
                        input logic ok, input logic [21:0] v);
      @(posedge ref_clk);
      go       <= 1'b1;
      goLine   <= ln;
      ackDelay <= dly;
      @(posedge ref_clk);
      go       <= 1'b0;
      tick(50);
      `CHK("vector seen", ok, gotVec)
      if (ok)
      begin
         `CHK("vector", v, lastVec)
         `CHK("line", ln, lastLine)
         `CHK("latency", 5'(ieu_pkg::FETCH_CYCLES), latency)
      end
   endtask

   // Settle a pin at ~lvl, move it to lvl, check pulse and stamp
   task automatic ext_edge(input int ch, input logic rise, input logic en,
                           input logic lvl, input logic exp);
      int          p;
      logic [15:0] s;
      p = (ch > 2) ? 2 : ch;
      @(posedge ref_clk);
      foreach (cfg[k]) cfg[k] <= '{enable: (k == ch) ? en : 1'b0,
                                   rising: rise};
      pin[p] <= ~lvl;
      repeat (6) @(posedge ref_clk);
      pin[p] <= lvl;
      tick(4);
      `CHK("ext pulse", exp, extOut[ch])
      s = stamps[p*16 +: 16];
      if (exp && ch < 3) `CHK("stamp clear", 1'b1, s <= 16'h0001)
      tick(1);
      `CHK("ext width", 1'b0, extOut[ch])
      tick(9);
      if (ch < 3) `CHK("stamp run", s + 16'h000a, stamps[p*16 +: 16])
   endtask

   // Print counts and verdict, end the run
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      {srst, periphReq, reqEnable, timer0Irq, timer1Irq} = '0;
      srst = 1'b1;
      {timer1Route, timer2Irq, vecWrEn, vecWrIdx, vecWrData} = '0;
      {pin, go, goLine, ackDelay, seenCpu, seenPer} = '0;
      foreach (cfg[k]) cfg[k] = '{enable: 1'b0, rising: 1'b1};
      lpMode = ieu_pkg::LPM_RUN;
      {errorCnt, samplesChecked, cycles} = '0;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      tick(1);
      `CHK("lines after reset", 12'h000, cpuIntLines)
      `CHK("valid after reset", 1'b0, vecRsp.valid)
      // All requests on: only the six wired groups can rise
      @(posedge ref_clk);
      periphReq <= '1;
      reqEnable <= '1;
      tick(3);
      `CHK("all groups", 12'h03f, cpuIntLines)
      // Top request of each wired group, enabled then disabled
      for (int g = 0; g < 6; g++)
      begin
         @(posedge ref_clk);
         periphReq <= 45'h1 << ((g == 5) ? 44 : g * 8 + 7);
         tick(3);
         `CHK("group line", 12'h1 << g, cpuIntLines)
         @(posedge ref_clk);
         reqEnable <= ~(96'h1 << ((g == 5) ? 44 : g * 8 + 7));
         tick(3);
         `CHK("gated line", 12'h000, cpuIntLines)
         @(posedge ref_clk);
         reqEnable <= '1;
      end
      // Timer zero through request six, timers one and two direct
      @(posedge ref_clk);
      periphReq   <= '0;
      timer0Irq   <= 1'b1;
      timer1Irq   <= 1'b1;
      timer1Route <= 1'b1;
      timer2Irq   <= 1'b1;
      tick(3);
      `CHK("timer zero", 12'h001, cpuIntLines)
      `CHK("line thirteen", 1'b1, line13)
      `CHK("line fourteen", 1'b1, line14)
      @(posedge ref_clk);
      reqEnable <= ~96'h40;
      timer1Irq <= 1'b0;
      timer2Irq <= 1'b0;
      tick(3);
      `CHK("timer zero off", 12'h000, cpuIntLines)
      `CHK("thirteen off", 1'b0, line13)
      `CHK("fourteen off", 1'b0, line14)
      // Vector fetch with priority inside group two
      vec_wr(7'h09, 22'h0a5a01);
      vec_wr(7'h0a, 22'h15a5a2);
      vec_wr(7'h0c, 22'h3c3c03);
      @(posedge ref_clk);
      timer0Irq <= 1'b0;
      periphReq <= 45'h1600;
      reqEnable <= ~96'h200;
      fetch(4'h2, 4'h0, 1'b1, 22'h15a5a2);
      @(posedge ref_clk);
      reqEnable <= ~96'h600;
      fetch(4'h2, 4'h3, 1'b1, 22'h3c3c03);
      vec_wr(7'h0c, 22'h2d2d2d);
      fetch(4'h2, 4'h0, 1'b1, 22'h2d2d2d);
      fetch(4'hd, 4'h0, 1'b0, 22'h000000);
      fetch(4'h7, 4'h1, 1'b0, 22'h000000);
      // External inputs: both polarities, wrong edge, disabled
      for (int ch = 0; ch < 4; ch++)
      begin
         ext_edge(ch, 1'b1, 1'b1, 1'b1, 1'b1);
         ext_edge(ch, 1'b0, 1'b1, 1'b0, 1'b1);
         ext_edge(ch, 1'b0, 1'b1, 1'b1, 1'b0);
         ext_edge(ch, 1'b1, 1'b0, 1'b1, 1'b0);
      end
      // Idle: quiet, then an enabled request wakes the CPU
      @(posedge ref_clk);
      lpMode    <= ieu_pkg::LPM_IDLE;
      periphReq <= '0;
      reqEnable <= '1;
      tick(4);
      seenCpu = 1'b0;
      tick(8);
      `CHK("idle quiet", 1'b0, seenCpu)
      @(posedge ref_clk);
      periphReq <= 45'h8;
      tick(8);
      `CHK("idle wake", 1'b1, seenCpu)
      // Standby: an external edge wakes CPU and peripherals
      @(posedge ref_clk);
      lpMode    <= ieu_pkg::LPM_STANDBY;
      periphReq <= '0;
      tick(4);
      {seenCpu, seenPer} = 2'b00;
      ext_edge(0, 1'b1, 1'b1, 1'b1, 1'b1);
      `CHK("standby cpu", 1'b1, seenCpu)
      `CHK("standby periph", 1'b1, seenPer)
      // Halt: request and maskable edge stay asleep, nonmaskable wakes
      @(posedge ref_clk);
      lpMode    <= ieu_pkg::LPM_HALT;
      periphReq <= 45'h8;
      tick(4);
      seenCpu = 1'b0;
      ext_edge(0, 1'b1, 1'b1, 1'b1, 1'b1);
      `CHK("halt no wake", 1'b0, seenCpu)
      ext_edge(3, 1'b1, 1'b1, 1'b1, 1'b1);
      `CHK("halt nmi wake", 1'b1, seenCpu)
      tally_and_finish();
   end
endmodule
